// ===== logic/gsm_pkg.sv
// constants and types of the fuel gauge sleep mode controller
// Overview of operation
// - wake after interval, one conversion set, sleep
// - sleep powers analog down, ultra-low-power oscillator times
// - accumulator tick every half second keeps running
// - grounded aux: pack below cell-low trip enters
// - analog aux below aux trip enters sleep
// - sleep request bit enters periodic-wake state
// - current magnitude below low-current trip enters
// - interval is 2^(div+mult) half seconds
// - clear request or wake condition returns run
// - charge current above threshold wakes to run
// - pack voltage above rise level wakes
// - storage: no conversions, accumulation or bus
// - storage bit or low pack arms storage
// - both lines low long enough enter storage
// - both lines high long enough exit storage
// - one slave address, CRC-8 packet error check
// - divider 0..7 gives 0.5 s to 64 s
package gsm_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 8;
    // line hold times, in ns
    localparam int STORAGE_ENTRY_LOW_TIME_NS = 2000000;
    localparam int WAKE_HIGH_TIME_NS = 1000000;
    // default ultra-low-power oscillator edges per half second
    localparam int ULP_EDGES_HALF_SEC = 16384;
    // default slave address, a neutral value
    localparam logic [6:0] SLAVE_ADDR_RST = 7'h0B;
    // register byte offsets
    localparam logic [7:0] OFS_OPERATING_MODE_REGISTER = 8'h00;
    localparam logic [7:0] OFS_CONV_CFG = 8'h04;
    localparam logic [7:0] OFS_TRIP_CTRL = 8'h08;
    localparam logic [7:0] OFS_CELL_LOW = 8'h0C;
    localparam logic [7:0] OFS_AUX_LOW = 8'h10;
    localparam logic [7:0] OFS_LOW_CUR = 8'h14;
    localparam logic [7:0] OFS_CHG_WAKE = 8'h18;
    localparam logic [7:0] OFS_PACK_RISE = 8'h1C;
    localparam logic [7:0] OFS_STORE_TRIP = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_PEC = 8'h28;
    localparam logic [7:0] OFS_SLAVE_ADDR = 8'h2C;
    // operating mode register fields
    localparam int OPM_SLEEP_REQ = 0;
    localparam int OPM_STORAGE = 1;
    localparam int OPM_MULT_LO = 2;
    // converter config register fields
    localparam int CFG_AUX_ANALOG = 3;
    // trip control enable bits
    localparam int TC_CELL_LOW = 0;
    localparam int TC_AUX_LOW = 1;
    localparam int TC_LOW_CUR = 2;
    localparam int TC_CHG_WAKE = 3;
    localparam int TC_PACK_RISE = 4;
    localparam int TC_STORAGE = 5;
    // reset values
    localparam logic [15:0] REG_RST = 16'h0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // packet error check polynomial x^8+x^2+x+1
    localparam logic [7:0] CRC_POLY = 8'h07;
    // power modes
    typedef enum logic [1:0] {
        GSM_RUN = 2'b00,
        GSM_NAP = 2'b01,
        GSM_WAKE = 2'b10,
        GSM_STORE = 2'b11
    } gsm_mode_t;
endpackage

// ===== logic/gsm_hold_timer.sv
// level hold timer: done once the level has held for HOLD cycles
`timescale 1ns/1ps
`default_nettype none
module gsm_hold_timer #(
    parameter int HOLD = 16
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic level, // condition being timed
    output logic done // held long enough
);
    localparam int CW = $clog2(HOLD + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD);
    logic [CW-1:0] cnt_r; // cycles the level has held

    generate
        if (HOLD < 1)
        begin : g_chk
            $error("gsm_hold_timer: HOLD must be at least 1");
        end
    endgenerate

    // restart on every drop of the level, saturate at the hold time
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_r <= '0;
        else if (!level)
            cnt_r <= '0;
        else if (cnt_r != LAST)
            cnt_r <= cnt_r + 1'b1;
    end

    assign done = level && (cnt_r == LAST);
endmodule
`default_nettype wire

// ===== logic/gsm_ctrl.sv
// sleep and storage mode controller with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module gsm_ctrl #(
    parameter int ULP_EDGES_HALF = gsm_pkg::ULP_EDGES_HALF_SEC, // ulp edges per 0.5 s
    parameter int LOW_HOLD_CYC = (gsm_pkg::STORAGE_ENTRY_LOW_TIME_NS
        + gsm_pkg::CLK_PERIOD_NS - 1) / gsm_pkg::CLK_PERIOD_NS, // entry low time
    parameter int HIGH_HOLD_CYC = (gsm_pkg::WAKE_HIGH_TIME_NS
        + gsm_pkg::CLK_PERIOD_NS - 1) / gsm_pkg::CLK_PERIOD_NS // wake high time
) (
    input wire logic clk, // 125 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [7:0] s_axi_awaddr, // write byte address
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    output logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    input wire logic [7:0] s_axi_araddr, // read byte address
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    input wire logic [15:0] pack_voltage_pin, // pack voltage result
    input wire logic [15:0] aux_analog_input, // aux input result
    input wire logic signed [15:0] current_meas, // current, positive charges
    input wire logic conv_done, // conversion set finished
    input wire logic ulp_osc, // ultra-low-power oscillator pin
    input wire logic scl_in, // bus clock line level
    input wire logic sda_in, // bus data line level
    input wire logic [7:0] pec_byte, // byte for packet error check
    input wire logic pec_valid, // pec byte strobe
    input wire logic pec_clear, // restart pec
    output logic analog_en, // analog circuitry powered
    output logic conv_start, // start one conversion set
    output logic accum_tick, // half-second accumulator update
    output logic smbus_ignore, // two-wire bus traffic ignored
    output logic [1:0] power_mode, // current gsm_mode_t
    output logic [6:0] slave_addr, // the single bus slave address
    output logic [7:0] pec_crc // running crc-8
);
    generate
        if (ULP_EDGES_HALF < 2)
        begin : g_chk
            $error("gsm_ctrl: ULP_EDGES_HALF must be at least 2");
        end
    endgenerate

    // pin synchronisers, stage one read only by stage two
    logic [2:0] ulp_s_r; // ulp sync and edge stage
    logic [1:0] scl_s_r; // bus clock sync
    logic [1:0] sda_s_r; // bus data sync
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ulp_s_r <= '0;
            scl_s_r <= '1; // lines idle high, so no false fall after reset
            sda_s_r <= '1;
        end
        else
        begin
            ulp_s_r <= {ulp_s_r[1:0], ulp_osc};
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
        end
    end
    wire ulp_edge = ulp_s_r[1] && !ulp_s_r[2];
    wire both_low = !scl_s_r[1] && !sda_s_r[1];
    wire both_high = scl_s_r[1] && sda_s_r[1];

    // half-second divider on the ulp oscillator, runs in every mode
    localparam int UW = $clog2(ULP_EDGES_HALF);
    localparam logic [UW-1:0] ULP_LAST = UW'(ULP_EDGES_HALF - 1);
    logic [UW-1:0] ulp_cnt_r; // ulp edges this half second
    wire half_tick = ulp_edge && (ulp_cnt_r == ULP_LAST);
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ulp_cnt_r <= '0;
        else if (half_tick)
            ulp_cnt_r <= '0;
        else if (ulp_edge)
            ulp_cnt_r <= ulp_cnt_r + 1'b1;
    end

    // registers
    logic [15:0] operating_mode_register_r, cfg_r, trip_r, cell_low_r, aux_low_r; // control words, cell and aux trip levels
    logic [15:0] low_cur_r, chg_wake_r, pack_rise_r, store_trip_r; // trip levels
    logic [6:0] saddr_r; // slave address
    gsm_pkg::gsm_mode_t state_r, state_nxt; // power mode
    logic by_req_r; // periodic-wake entered by request
    logic seen_high_r; // lines were high before the fall
    logic [14:0] nap_cnt_r, nap_cnt_nxt; // half seconds left asleep

    // trip comparisons
    wire aux_analog = cfg_r[gsm_pkg::CFG_AUX_ANALOG];
    wire [15:0] cur_mag = current_meas[15] ? 16'(-current_meas) : current_meas;
    wire cell_trip = !aux_analog && trip_r[gsm_pkg::TC_CELL_LOW]
        && (pack_voltage_pin < cell_low_r);
    wire aux_trip = aux_analog && trip_r[gsm_pkg::TC_AUX_LOW]
        && (aux_analog_input < aux_low_r);
    wire cur_trip = trip_r[gsm_pkg::TC_LOW_CUR] && (cur_mag < low_cur_r);
    wire sleep_req = operating_mode_register_r[gsm_pkg::OPM_SLEEP_REQ];
    wire nap_go = sleep_req || cell_trip || aux_trip || cur_trip;
    wire chg_wake = trip_r[gsm_pkg::TC_CHG_WAKE] && !current_meas[15]
        && (current_meas > $signed(chg_wake_r));
    wire rise_wake = trip_r[gsm_pkg::TC_PACK_RISE]
        && (pack_voltage_pin > pack_rise_r);
    wire wake_go = (by_req_r && !sleep_req) || chg_wake || rise_wake;
    wire store_arm = operating_mode_register_r[gsm_pkg::OPM_STORAGE] || (trip_r[gsm_pkg::TC_STORAGE]
        && (pack_voltage_pin < store_trip_r));
    wire low_done, high_done; // hold timers expired
    wire store_go = store_arm && seen_high_r && low_done;
    wire [3:0] nap_exp = {1'b0, cfg_r[2:0]} + {1'b0, operating_mode_register_r[4:2]};
    wire [14:0] nap_load = 15'(16'h0001 << nap_exp);

    gsm_hold_timer #(.HOLD(LOW_HOLD_CYC)) u_low_hold (
        .clk(clk),
        .rstn(rstn),
        .level(both_low),
        .done(low_done)
    );
    gsm_hold_timer #(.HOLD(HIGH_HOLD_CYC)) u_high_hold (
        .clk(clk),
        .rstn(rstn),
        .level(both_high),
        .done(high_done)
    );

    // mode sequencer; storage is checked first in every non-storage mode
    always_comb
    begin
        state_nxt = state_r;
        nap_cnt_nxt = nap_cnt_r;
        case (state_r)
            gsm_pkg::GSM_RUN:
            begin
                if (store_go)
                    state_nxt = gsm_pkg::GSM_STORE;
                else if (nap_go)
                begin
                    state_nxt = gsm_pkg::GSM_NAP;
                    nap_cnt_nxt = nap_load;
                end
            end
            gsm_pkg::GSM_NAP:
            begin
                if (store_go)
                    state_nxt = gsm_pkg::GSM_STORE;
                else if (wake_go)
                    state_nxt = gsm_pkg::GSM_RUN;
                else if (half_tick)
                begin
                    nap_cnt_nxt = nap_cnt_r - 15'h0001;
                    if (nap_cnt_r == 15'h0001)
                        state_nxt = gsm_pkg::GSM_WAKE;
                end
            end
            gsm_pkg::GSM_WAKE:
            begin
                if (store_go)
                    state_nxt = gsm_pkg::GSM_STORE;
                else if (wake_go)
                    state_nxt = gsm_pkg::GSM_RUN;
                else if (conv_done)
                begin
                    state_nxt = gsm_pkg::GSM_NAP;
                    nap_cnt_nxt = nap_load;
                end
            end
            gsm_pkg::GSM_STORE:
            begin
                if (high_done)
                    state_nxt = gsm_pkg::GSM_RUN;
            end
            default:
                state_nxt = gsm_pkg::GSM_RUN;
        endcase
    end

    // mode state and registered mode outputs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= gsm_pkg::GSM_RUN;
            nap_cnt_r <= '0;
            by_req_r <= 1'b0;
            seen_high_r <= 1'b0;
            analog_en <= 1'b1;
            conv_start <= 1'b0;
            accum_tick <= 1'b0;
            smbus_ignore <= 1'b0;
            power_mode <= gsm_pkg::GSM_RUN;
        end
        else
        begin
            state_r <= state_nxt;
            nap_cnt_r <= nap_cnt_nxt;
            if (state_r == gsm_pkg::GSM_RUN)
                by_req_r <= sleep_req;
            // a fall only counts after the lines were seen high
            if (state_nxt == gsm_pkg::GSM_STORE)
                seen_high_r <= 1'b0;
            else if (both_high)
                seen_high_r <= 1'b1;
            analog_en <= (state_nxt != gsm_pkg::GSM_NAP)
                && (state_nxt != gsm_pkg::GSM_STORE);
            conv_start <= (state_nxt == gsm_pkg::GSM_WAKE)
                && (state_r != gsm_pkg::GSM_WAKE);
            accum_tick <= half_tick && (state_r != gsm_pkg::GSM_STORE);
            smbus_ignore <= (state_nxt == gsm_pkg::GSM_STORE);
            power_mode <= state_nxt;
        end
    end

    // axi4-lite write path: address and data taken in either order
    logic aw_hold_r, w_hold_r; // halves captured
    logic [7:0] aw_addr_r; // captured address
    logic [31:0] w_data_r; // captured data
    logic [3:0] w_strb_r; // captured strobes
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire wr_do = aw_hold_r && w_hold_r;
    wire aw_hold_nxt = (aw_hold_r && !wr_do) || aw_fire;
    wire w_hold_nxt = (w_hold_r && !wr_do) || w_fire;
    wire bvalid_nxt = wr_do || (s_axi_bvalid && !s_axi_bready);
    wire [15:0] wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [15:0] wval = w_data_r[15:0];
    wire wr_hit = (aw_addr_r <= gsm_pkg::OFS_SLAVE_ADDR) && (aw_addr_r[1:0] == 2'b00)
        && (aw_addr_r != gsm_pkg::OFS_STATUS) && (aw_addr_r != gsm_pkg::OFS_PEC);
    wire store_set = wr_do && (aw_addr_r == gsm_pkg::OFS_OPERATING_MODE_REGISTER) && w_strb_r[0]
        && wval[gsm_pkg::OPM_STORAGE];
    wire leave_store = (state_r == gsm_pkg::GSM_STORE) && high_done;

    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [15:0] val, input logic [15:0] msk);
        merge = (old & ~msk) | (val & msk);
    endfunction

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gsm_pkg::RESP_OKAY;
        end
        else
        begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            if (aw_fire)
                aw_addr_r <= s_axi_awaddr;
            if (w_fire)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_hold_nxt && !bvalid_nxt;
            s_axi_wready <= !w_hold_nxt && !bvalid_nxt;
            s_axi_bvalid <= bvalid_nxt;
            if (wr_do)
                s_axi_bresp <= wr_hit ? gsm_pkg::RESP_OKAY : gsm_pkg::RESP_SLVERR;
        end
    end

    // register writes; a storage write wins over the exit clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            operating_mode_register_r <= gsm_pkg::REG_RST;
            cfg_r <= gsm_pkg::REG_RST;
            trip_r <= gsm_pkg::REG_RST;
            cell_low_r <= gsm_pkg::REG_RST;
            aux_low_r <= gsm_pkg::REG_RST;
            low_cur_r <= gsm_pkg::REG_RST;
            chg_wake_r <= gsm_pkg::REG_RST;
            pack_rise_r <= gsm_pkg::REG_RST;
            store_trip_r <= gsm_pkg::REG_RST;
            saddr_r <= gsm_pkg::SLAVE_ADDR_RST;
        end
        else
        begin
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_OPERATING_MODE_REGISTER))
                operating_mode_register_r <= merge(operating_mode_register_r, wval, wmask);
            else if (leave_store)
                operating_mode_register_r <= gsm_pkg::REG_RST; // volatile mode bits lost
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_CONV_CFG))
                cfg_r <= merge(cfg_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_TRIP_CTRL))
                trip_r <= merge(trip_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_CELL_LOW))
                cell_low_r <= merge(cell_low_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_AUX_LOW))
                aux_low_r <= merge(aux_low_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_LOW_CUR))
                low_cur_r <= merge(low_cur_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_CHG_WAKE))
                chg_wake_r <= merge(chg_wake_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_PACK_RISE))
                pack_rise_r <= merge(pack_rise_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_STORE_TRIP))
                store_trip_r <= merge(store_trip_r, wval, wmask);
            if (wr_do && (aw_addr_r == gsm_pkg::OFS_SLAVE_ADDR) && w_strb_r[0])
                saddr_r <= wval[6:0];
        end
    end
    assign slave_addr = saddr_r;

    // packet error check, crc-8 one byte per strobe
    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] b);
        logic [7:0] c;
        c = crc ^ b;
        for (int i = 0; i < 8; i++)
            c = c[7] ? ((c << 1) ^ gsm_pkg::CRC_POLY) : (c << 1);
        crc8 = c;
    endfunction
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pec_crc <= '0;
        else if (pec_clear)
            pec_crc <= '0;
        else if (pec_valid)
            pec_crc <= crc8(pec_crc, pec_byte);
    end

    // axi4-lite read path
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [15:0] status_w = {12'h000, analog_en, store_arm, state_r};
    logic [15:0] rd_val; // selected register
    logic rd_ok; // address mapped
    always_comb
    begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            gsm_pkg::OFS_OPERATING_MODE_REGISTER: rd_val = operating_mode_register_r;
            gsm_pkg::OFS_CONV_CFG: rd_val = cfg_r;
            gsm_pkg::OFS_TRIP_CTRL: rd_val = trip_r;
            gsm_pkg::OFS_CELL_LOW: rd_val = cell_low_r;
            gsm_pkg::OFS_AUX_LOW: rd_val = aux_low_r;
            gsm_pkg::OFS_LOW_CUR: rd_val = low_cur_r;
            gsm_pkg::OFS_CHG_WAKE: rd_val = chg_wake_r;
            gsm_pkg::OFS_PACK_RISE: rd_val = pack_rise_r;
            gsm_pkg::OFS_STORE_TRIP: rd_val = store_trip_r;
            gsm_pkg::OFS_STATUS: rd_val = status_w;
            gsm_pkg::OFS_PEC: rd_val = {8'h00, pec_crc};
            gsm_pkg::OFS_SLAVE_ADDR: rd_val = {9'h000, saddr_r};
            default:
            begin
                rd_val = 16'h0000;
                rd_ok = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= gsm_pkg::RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= rd_ok ? gsm_pkg::RESP_OKAY : gsm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    // checks
    chk_nap_analog_off: assert property (@(posedge clk) disable iff (!rstn)
        state_r == gsm_pkg::GSM_NAP |-> !analog_en)
        else $error("analog powered while asleep");
    chk_single_conv: assert property (@(posedge clk) disable iff (!rstn)
        conv_start |-> state_r == gsm_pkg::GSM_WAKE ##1 !conv_start)
        else $error("conversion start not single");
    chk_tick_continues: assert property (@(posedge clk) disable iff (!rstn)
        half_tick && state_r != gsm_pkg::GSM_STORE |=> accum_tick)
        else $error("accumulator tick lost");
    chk_storage_quiet: assert property (@(posedge clk) disable iff (!rstn)
        state_r == gsm_pkg::GSM_STORE |-> smbus_ignore && !analog_en ##1 !accum_tick)
        else $error("storage mode not quiet");
    chk_entry_trip: assert property (@(posedge clk) disable iff (!rstn)
        state_r == gsm_pkg::GSM_RUN && nap_go && !store_go
        |=> state_r == gsm_pkg::GSM_NAP && nap_cnt_r == $past(nap_load))
        else $error("periodic-wake entry missed");
    chk_storage_prio: assert property (@(posedge clk) disable iff (!rstn)
        state_r != gsm_pkg::GSM_STORE && store_go |=> state_r == gsm_pkg::GSM_STORE)
        else $error("storage entry missed");
    chk_wake_exit: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == gsm_pkg::GSM_NAP || state_r == gsm_pkg::GSM_WAKE) && wake_go
        && !store_go |=> state_r == gsm_pkg::GSM_RUN)
        else $error("wake condition ignored");
    chk_storage_exit: assert property (@(posedge clk) disable iff (!rstn)
        leave_store |=> state_r == gsm_pkg::GSM_RUN ##1 !smbus_ignore)
        else $error("storage exit wrong");
    chk_storage_arm: assert property (@(posedge clk) disable iff (!rstn)
        store_set |=> operating_mode_register_r[gsm_pkg::OPM_STORAGE] && store_arm)
        else $error("storage not armed");
    chk_nap_wake: assert property (@(posedge clk) disable iff (!rstn)
        state_r == gsm_pkg::GSM_NAP && half_tick && nap_cnt_r == 15'h0001
        && !wake_go && !store_go |=> conv_start && state_r == gsm_pkg::GSM_WAKE)
        else $error("interval expiry did not wake");
endmodule
`default_nettype wire

// ===== sim/gsm_line_model.sv
// host side model of the two bus lines, pulled up when released
`timescale 1ns/1ps
`default_nettype none
module gsm_line_model (
    input wire logic pull_low, // host holds both lines low
    output logic scl, // clock line level
    output logic sda // data line level
);
    // released lines float back to the pull-up level
    assign scl = ~pull_low;
    assign sda = ~pull_low;
endmodule
`default_nettype wire

// ===== sim/gsm_ctrl_tb.sv
// self-checking bench of the sleep and storage mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module gsm_ctrl_tb;
    logic clk = 0, rstn = 0, ulp_osc = 0, conv_done = 0, pull_low = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, d;
    logic [15:0] pack_voltage_pin = 16'hFFFF; // stays above every trip
    logic signed [15:0] current_meas = 16'sh0000;
    logic [7:0] pec_byte = 8'h00;
    logic pec_valid = 0, pec_clear = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic analog_en, conv_start, accum_tick, smbus_ignore, scl_in, sda_in;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, power_mode;
    wire logic [31:0] s_axi_rdata;
    wire logic [6:0] slave_addr;
    wire logic [7:0] pec_crc;
    int err_total = 0, samples_checked = 0, i, n;
    logic [1:0] r;
    // rows: address, write value, read value, write response, read response
    logic [43:0] rows [5] = '{{8'h0C, 16'h1234, 16'h1234, 2'h0, 2'h0},
        {8'h24, 16'hFFFF, 16'h0008, 2'h2, 2'h0}, {8'h28, 16'h00FF, 16'h0000, 2'h2, 2'h0},
        {8'h30, 16'h0001, 16'h0000, 2'h2, 2'h2}, {8'h2C, 16'h0055, 16'h0055, 2'h0, 2'h0}};
    always #4 clk = ~clk;
    // free running sleep oscillator, unrelated in phase
    always #62.5 ulp_osc = ~ulp_osc;
    gsm_line_model LM (.pull_low, .scl(scl_in), .sda(sda_in));
    // short hold times and a four-edge half second keep the run brief
    gsm_ctrl #(.ULP_EDGES_HALF(4), .LOW_HOLD_CYC(20), .HIGH_HOLD_CYC(20)) DUT (.clk, .rstn,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .pack_voltage_pin, .aux_analog_input(16'h0000),
        .current_meas, .conv_done, .ulp_osc, .scl_in, .sda_in, .pec_byte,
        .pec_valid, .pec_clear, .analog_en, .conv_start, .accum_tick,
        .smbus_ignore, .power_mode, .slave_addr, .pec_crc);
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    // counts half-second ticks up to the next wake, then ends the conversion set
    task automatic wake;
        n = 0;
        for (i = 0; i < 400 && !conv_start; i++)
        begin
            @(posedge clk);
            if (accum_tick) n++;
        end
        `CHK("wake mode", 2'h2, power_mode)
        conv_done <= 1;
        @(posedge clk);
        conv_done <= 0;
        @(posedge clk);
        `CHK("nap mode", 2'h1, power_mode)
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        `CHK("analog_en", 1'b1, analog_en)
        `CHK("slave_addr", 7'h0B, slave_addr)
        rstn <= 1;
        repeat (2) @(posedge clk);
        for (int k = 0; k < 5; k++)
        begin
            wr(rows[k][43:36], rows[k][35:20]);
            `CHK("bresp", rows[k][3:2], r)
            rd(rows[k][43:36]);
            `CHK("rdata", {16'h0000, rows[k][19:4]}, d)
            `CHK("rresp", rows[k][1:0], r)
        end
        `CHK("slave_addr", 7'h55, slave_addr)
        // sleep request, one multiplier step: two ticks per interval
        wr(8'h00, 16'h0005);
        repeat (3) @(posedge clk);
        `CHK("mode", 2'h1, power_mode)
        `CHK("analog_en", 1'b0, analog_en)
        wake();
        wake();
        `CHK("ticks", 2, n)
        wr(8'h00, 16'h0000);
        repeat (3) @(posedge clk);
        `CHK("mode", 2'h0, power_mode)
        // armed storage, lines low past the hold, then high past the hold
        wr(8'h00, 16'h0002);
        pull_low <= 1;
        repeat (40) @(posedge clk);
        `CHK("mode", 2'h3, power_mode)
        `CHK("ignore", 1'b1, smbus_ignore)
        pull_low <= 0;
        repeat (10) @(posedge clk);
        `CHK("mode", 2'h3, power_mode)
        repeat (30) @(posedge clk);
        `CHK("mode", 2'h0, power_mode)
        rd(8'h00);
        `CHK("operating_mode_register", 32'h0, d)
        // low current enters, charge current above threshold wakes
        current_meas <= 16'sh0032;
        wr(8'h14, 16'h0064);
        wr(8'h18, 16'h00C8);
        wr(8'h08, 16'h000C);
        repeat (3) @(posedge clk);
        `CHK("mode", 2'h1, power_mode)
        current_meas <= 16'sh012C;
        repeat (4) @(posedge clk);
        `CHK("mode", 2'h0, power_mode)
        // one crc-8 step over byte 01 from zero leaves the polynomial
        pec_byte <= 8'h01;
        pec_valid <= 1;
        @(posedge clk);
        pec_valid <= 0;
        @(posedge clk);
        `CHK("pec_crc", gsm_pkg::CRC_POLY, pec_crc)
        pec_clear <= 1;
        @(posedge clk);
        pec_clear <= 0;
        @(posedge clk);
        `CHK("pec_clear", 8'h00, pec_crc)
        // mid-run reset brings the address back at once
        rstn <= 0;
        @(posedge clk);
        `CHK("slave_addr", 7'h0B, slave_addr)
        end_sim();
    end
    initial
    begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
